// ==== rtl/adjust_if.sv ====
// carrier between the slice and its decimal correction unit
`timescale 1ns/1ps
interface adjust_if;
	logic [7:0] acc;
	logic       carry_in;
	logic       half_carry_in;
	logic [7:0] result;
	logic       carry_out;
	logic [7:0] addend;

	modport calc (
		input  acc,
		input  carry_in,
		input  half_carry_in,
		output result,
		output carry_out,
		output addend
	);

	modport user (
		output acc,
		output carry_in,
		output half_carry_in,
		input  result,
		input  carry_out,
		input  addend
	);
endinterface

// ==== rtl/dabc_defs.svh ====
// constants for the decimal adjust and bit complement datapath slice
// Behaviour
// - low nibble above nine or half carry set adds six to accumulator.
// - low correction sets carry only on carry out of bit seven; never clears.
// - carry set or high nibble above nine adds six to the high nibble.
// - carry out of high nibble sets carry; no carry leaves it unchanged.
// - decimal adjust leaves the overflow flag untouched.
// - whole correction in one cycle, adding 00H, 06H, 60H or 66H.
// - decimal adjust is one-byte opcode 1101_0100, one machine cycle.
// - bit invert flips the addressed bit; opcode plus bit address, one cycle.
`ifndef DABC_DEFS_SVH
`define DABC_DEFS_SVH

`define DABC_OP_DECIMAL_ADJUST 8'hD4
`define DABC_OP_INVERT_BIT     8'hB2
`define DABC_PSW_CARRY         7
`define DABC_PSW_HALF_CARRY    6
`define DABC_PSW_OVERFLOW      2
`define DABC_DIGIT_MAX         4'h9
`define DABC_LOW_FIX           8'h06
`define DABC_HIGH_FIX          8'h60
`define DABC_RESET_BYTE        8'h00
`define DABC_RESET_BIT         1'h0

`endif

// ==== rtl/dabc_pkg.sv ====
// types shared by the datapath slice
package dabc_pkg;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_DECIMAL_ADJUST,
		OP_INVERT_BIT
	} op_kind_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] program_status_word;
		logic [7:0] bit_addr;
		logic       bit_val;
		logic       acc_we;
		logic       psw_we;
		logic       bit_we;
		logic       done;
	} slice_state_t;

endpackage

// ==== rtl/decimal_adjust_bit_complement.sv ====
// decimal adjust and addressable bit invert slice of the core datapath
`timescale 1ns/1ps
`include "dabc_defs.svh"
module decimal_adjust_bit_complement (
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	input  wire logic       OP_VALID,
	input  wire logic [7:0] OPCODE,
	input  wire logic [7:0] OPERAND,
	input  wire logic [7:0] ACC_IN,
	input  wire logic [7:0] PSW_IN,
	input  wire logic       BIT_IN,
	output logic      [7:0] ACC_OUT,
	output logic            ACC_WE,
	output logic      [7:0] PSW_OUT,
	output logic            PSW_WE,
	output logic      [7:0] BIT_ADDR_OUT,
	output logic            BIT_OUT,
	output logic            BIT_WE,
	output logic            DONE
);
	dabc_pkg::slice_state_t state;
	dabc_pkg::slice_state_t next_state;
	dabc_pkg::op_kind_t     op_kind;
	adjust_if               adj ();

	decimal_correct u_correct (
		.port (adj.calc)
	);

	assign adj.acc           = ACC_IN;
	assign adj.carry_in      = PSW_IN[`DABC_PSW_CARRY];
	assign adj.half_carry_in = PSW_IN[`DABC_PSW_HALF_CARRY];

	always_comb begin
		op_kind = dabc_pkg::OP_NONE;
		if (OP_VALID) begin
			case (OPCODE)
				`DABC_OP_DECIMAL_ADJUST: op_kind = dabc_pkg::OP_DECIMAL_ADJUST;
				`DABC_OP_INVERT_BIT:     op_kind = dabc_pkg::OP_INVERT_BIT;
				default:                 op_kind = dabc_pkg::OP_NONE;
			endcase
		end
	end

	always_comb begin
		next_state        = state;
		next_state.acc_we = 1'b0;
		next_state.psw_we = 1'b0;
		next_state.bit_we = 1'b0;
		next_state.done   = 1'b0;
		case (op_kind)
			dabc_pkg::OP_DECIMAL_ADJUST: begin
				// result lands one edge after the opcode: one machine cycle
				next_state.acc    = adj.result;
				// only the carry bit may change; overflow and half carry ride through
				next_state.program_status_word    = PSW_IN;
				next_state.program_status_word[`DABC_PSW_CARRY] = adj.carry_out;
				next_state.acc_we = 1'b1;
				next_state.psw_we = 1'b1;
				next_state.done   = 1'b1;
			end
			dabc_pkg::OP_INVERT_BIT: begin
				// the caller supplies the latch value, not the pin, for port bits
				next_state.bit_addr = OPERAND;
				next_state.bit_val  = ~BIT_IN;
				next_state.bit_we   = 1'b1;
				next_state.done     = 1'b1;
			end
			default: begin
				next_state.done = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state.acc      <= `DABC_RESET_BYTE;
			state.program_status_word      <= `DABC_RESET_BYTE;
			state.bit_addr <= `DABC_RESET_BYTE;
			state.bit_val  <= `DABC_RESET_BIT;
			state.acc_we   <= 1'b0;
			state.psw_we   <= 1'b0;
			state.bit_we   <= 1'b0;
			state.done     <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign ACC_OUT      = state.acc;
	assign ACC_WE       = state.acc_we;
	assign PSW_OUT      = state.program_status_word;
	assign PSW_WE       = state.psw_we;
	assign BIT_ADDR_OUT = state.bit_addr;
	assign BIT_OUT      = state.bit_val;
	assign BIT_WE       = state.bit_we;
	assign DONE         = state.done;

	// checks: net change in the accumulator is the addend, read back modulo 256
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_da_req;
		OP_VALID && (OPCODE == `DABC_OP_DECIMAL_ADJUST);
	endsequence

	sequence s_inv_req;
		OP_VALID && (OPCODE == `DABC_OP_INVERT_BIT);
	endsequence

	sequence s_low_big;
		s_da_req ##0 ((ACC_IN[3:0] > 4'h9) || PSW_IN[6]);
	endsequence

	sequence s_written;
		ACC_WE && PSW_WE && DONE;
	endsequence

	a_low_fix: assert property (
		s_low_big |=> s_written ##0 ((8'(ACC_OUT - $past(ACC_IN)) & 8'h0F) == 8'h06))
		else $error("low digit not corrected by six");

	a_low_skip: assert property (
		s_da_req ##0 (ACC_IN[3:0] <= 4'h9) && !PSW_IN[6]
			|=> (8'(ACC_OUT - $past(ACC_IN)) & 8'h0F) == 8'h00)
		else $error("low digit changed without cause");

	a_carry_sticky: assert property (
		s_da_req ##0 PSW_IN[7] |=> PSW_OUT[7])
		else $error("decimal adjust cleared a set carry");

	a_high_fix: assert property (
		s_da_req ##0 ((ACC_IN[7:4] > 4'h9) || PSW_IN[7])
			|=> (8'(ACC_OUT - $past(ACC_IN)) & 8'hF0) == 8'h60)
		else $error("high digit not corrected by six");

	a_carry_set: assert property (
		s_da_req ##0 (ACC_IN >= 8'h9A) |=> PSW_OUT[7] && PSW_WE)
		else $error("high digit carry did not set carry");

	a_ov_keep: assert property (
		s_da_req |=> PSW_OUT[2] == $past(PSW_IN[2]))
		else $error("overflow flag modified");

	a_addend_set: assert property (
		s_da_req |=> (8'(ACC_OUT - $past(ACC_IN)) inside {8'h00, 8'h06, 8'h60, 8'h66}))
		else $error("accumulator addend outside the four constants");

	a_addend_const: assert property (
		s_da_req |-> (adj.addend == 8'h00) || (adj.addend == `DABC_LOW_FIX)
			|| (adj.addend == `DABC_HIGH_FIX)
			|| (adj.addend == (`DABC_LOW_FIX | `DABC_HIGH_FIX)))
		else $error("correction unit addend outside the four constants");

	a_one_cycle: assert property (
		s_da_req ##1 !OP_VALID |-> DONE ##1 !DONE)
		else $error("decimal adjust not exactly one cycle");

	a_bit_invert: assert property (
		s_inv_req |=> BIT_WE && DONE && !ACC_WE && (BIT_OUT != $past(BIT_IN))
			&& (BIT_ADDR_OUT == $past(OPERAND)))
		else $error("addressed bit not inverted");

	a_status_keep: assert property (
		s_da_req |=> PSW_OUT[6:0] == $past(PSW_IN[6:0]))
		else $error("status bits other than carry modified");

endmodule

// ==== rtl/decimal_correct.sv ====
// two-step packed-BCD correction of the accumulator, purely combinational
`timescale 1ns/1ps
`include "dabc_defs.svh"
module decimal_correct (
	adjust_if.calc port
);
	logic [8:0] low_sum;
	logic [8:0] high_sum;
	logic       low_fix;
	logic       high_fix;
	logic       carry_mid;

	always_comb begin
		low_fix   = (port.acc[3:0] > `DABC_DIGIT_MAX) || port.half_carry_in;
		low_sum   = {1'b0, port.acc} + {1'b0, (low_fix ? `DABC_LOW_FIX : 8'h00)};
		// only a ripple through bit seven counts, and a set carry stays set
		carry_mid = port.carry_in | low_sum[8];
		high_fix  = carry_mid || (low_sum[7:4] > `DABC_DIGIT_MAX);
		high_sum  = {1'b0, low_sum[7:0]} + {1'b0, (high_fix ? `DABC_HIGH_FIX : 8'h00)};
		port.carry_out = carry_mid | high_sum[8];
		port.result    = high_sum[7:0];
		port.addend    = port.result - port.acc;
	end
endmodule

// ==== testbench/decimal_adjust_bit_complement_bench.sv ====
// self-checking bench for the decimal adjust and bit invert slice
`timescale 1ns/1ps
`include "dabc_defs.svh"
module decimal_adjust_bit_complement_bench;
	logic       clk, rst_n, op_valid, bit_in;
	logic [7:0] opcode, operand, acc_in, psw_in;
	logic [7:0] acc_out, psw_out, bit_addr;
	logic       acc_we, psw_we, bit_out, bit_we, done;
	logic [3:0] stb;
	logic [15:0] cases [8];
	int         err_count = 0;
	int         n_tests = 0;
	int         cycles = 0;

	assign stb = {acc_we, psw_we, done, bit_we};

	decimal_adjust_bit_complement dut (.CORE_CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid),
		.OPCODE(opcode), .OPERAND(operand), .ACC_IN(acc_in), .PSW_IN(psw_in),
		.BIT_IN(bit_in), .ACC_OUT(acc_out), .ACC_WE(acc_we), .PSW_OUT(psw_out),
		.PSW_WE(psw_we), .BIT_ADDR_OUT(bit_addr), .BIT_OUT(bit_out), .BIT_WE(bit_we),
		.DONE(done));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard: the whole run needs well under a hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// drives one request for one cycle, returns at the answer cycle
	task automatic issue(input logic v, input logic [7:0] op, input logic [7:0] a,
		input logic [7:0] p, input logic [7:0] ad, input logic b);
		@(negedge clk);
		op_valid = v;
		opcode = op;
		acc_in = a;
		psw_in = p;
		operand = ad;
		bit_in = b;
		@(negedge clk);
		op_valid = 1'b0;
	endtask

	// two-step correction worked out independently, returns {acc, psw}
	function automatic logic [15:0] exp_da(input logic [7:0] a, input logic [7:0] p);
		logic [8:0] s;
		logic       c;
		s = {1'b0, a};
		if (a[3:0] > 4'h9 || p[6]) begin
			s = s + 9'h006;
		end
		c = p[7] | s[8];
		if (c || s[7:4] > 4'h9) begin
			s = {1'b0, s[7:0]} + 9'h060;
		end
		c = c | s[8];
		exp_da = {s[7:0], c, p[6:0]};
	endfunction

	task automatic da_case(input logic [7:0] a, input logic [7:0] p);
		issue(1'b1, `DABC_OP_DECIMAL_ADJUST, a, p, 8'h5A, 1'b0);
		chk({acc_out, psw_out}, exp_da(a, p), "adjust result");
		chk(stb, 4'hE, "adjust strobes");
		@(negedge clk);
		chk(stb, 4'h0, "strobes after");
	endtask

	task automatic test_da_walk();
		da_case(8'hBE, 8'h00);
	endtask

	// boundaries of both nibbles, carry in, low carry out, other flags set
	task automatic test_da_table();
		cases = '{16'h99C4, 16'h9A00, 16'hFA40, 16'h1280, 16'h123D, 16'hC900, 16'h0F04,
			16'hA07B};
		foreach (cases[i]) begin
			da_case(cases[i][15:8], cases[i][7:0]);
		end
	endtask

	task automatic test_invert();
		for (int i = 0; i < 4; i++) begin
			issue(1'b1, `DABC_OP_INVERT_BIT, 8'h33, 8'h00, i[0] ? 8'hFF : 8'h00, i[1]);
			chk({bit_addr, 7'h00, bit_out}, {i[0] ? 8'hFF : 8'h00, 7'h00, ~i[1]}, "bit");
			chk(stb, 4'h3, "invert strobes");
		end
	endtask

	// refused requests must leave data and strobes alone
	task automatic test_refused();
		issue(1'b1, 8'hF4, 8'h0B, 8'h00, 8'h12, 1'b0);
		// last adjust was A0h with flags 7Bh, which leaves 06h
		chk({acc_out, stb}, {8'h06, 4'h0}, "foreign opcode");
		issue(1'b0, `DABC_OP_DECIMAL_ADJUST, 8'h0B, 8'h00, 8'h12, 1'b0);
		chk({acc_out, stb}, {8'h06, 4'h0}, "idle request");
	endtask

	task automatic test_back_to_back();
		@(negedge clk);
		op_valid = 1'b1;
		opcode = `DABC_OP_DECIMAL_ADJUST;
		acc_in = 8'h9A;
		psw_in = 8'h00;
		@(negedge clk);
		opcode = `DABC_OP_INVERT_BIT;
		operand = 8'h91;
		bit_in = 1'b1;
		chk({acc_out, psw_out, 4'h0, stb}, {16'h0080, 8'h0E}, "first of pair");
		@(negedge clk);
		op_valid = 1'b0;
		chk({bit_addr, acc_out, 3'h0, bit_out, stb}, {16'h9100, 8'h03}, "second of pair");
	endtask

	initial begin
		rst_n = 1'b0;
		op_valid = 1'b0;
		opcode = 8'h00;
		operand = 8'h00;
		acc_in = 8'h00;
		psw_in = 8'h00;
		bit_in = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk({acc_out, psw_out, stb, 4'h0}, 24'h0, "reset");
		rst_n = 1'b1;
		test_da_walk();
		test_da_table();
		test_invert();
		test_refused();
		test_back_to_back();
		tally_and_finish();
	end
endmodule
